/* File: src/radio_mode_sequencer.v */
// Operating-mode state machine with serial register port
`timescale 1ns/100ps
`include "radio_seq_consts.vh"
module radio_mode_sequencer #(
    parameter [`TMR_W-1:0] POR_CYCLES = `CYC_POR,
    parameter [`TMR_W-1:0] XTAL_CYCLES = `CYC_XTAL
)
(
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire power_off_pin_i,
    input wire spi_sclk_i,
    input wire spi_mosi_i,
    input wire spi_sel_n_i,
    input wire [4:0] modem_flags_i,
    output reg spi_miso_o,
    output reg spi_miso_oe_o,
    output reg interrupt_out_n_o,
    output reg main_regulator_en_o,
    output reg low_power_regulator_en_o,
    output reg xtal_en_o,
    output reg xtal_buf_off_o,
    output reg pll_en_o,
    output reg vco_cal_o,
    output reg pa_en_o,
    output reg rx_front_end_en_o,
    output reg adc_cal_o,
    output reg modem_rx_en_o,
    output reg wake_timer_en_o,
    output reg lbd_en_o,
    output reg temp_sensor_en_o
);
    // ==========================================================
    // Sequencer states
    localparam [3:0] S_OFF = 4'h0;
    localparam [3:0] S_POR = 4'h1;
    localparam [3:0] S_IDLE = 4'h2;
    localparam [3:0] S_XTAL = 4'h3;
    localparam [3:0] S_PLL_ON = 4'h4;
    localparam [3:0] S_VCO = 4'h5;
    localparam [3:0] S_SETTLE = 4'h6;
    localparam [3:0] S_PA = 4'h7;
    localparam [3:0] S_TX = 4'h8;
    localparam [3:0] S_RXFE = 4'h9;
    localparam [3:0] S_ADC = 4'hA;
    localparam [3:0] S_RX = 4'hB;

    reg [3:0] state;
    reg [3:0] next_state;
    reg tmr_load;
    reg [`TMR_W-1:0] tmr_val;
    wire tmr_exp;

    reg [7:0] mode;
    reg [7:0] cal;
    reg [7:0] osc;
    reg [7:0] int_en2;
    reg [7:0] int_stat2;
    reg por_pending;

    wire s_sclk;
    wire s_mosi;
    wire s_sel_n;
    wire pwr_off;
    reg sclk_d;
    reg [2:0] bit_cnt;
    reg hdr_done;
    reg is_write;
    reg [6:0] addr;
    reg [6:0] shin;
    reg [7:0] shout;
    reg [6:0] rd_addr;
    reg [7:0] rdata;

    // ==========================================================
    // Pin synchronisers; select and power-off pin reset high, clock and data reset low
    pin_sync #(.W(4)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .init_i(4'h3),
        .async_i({spi_sclk_i, spi_mosi_i, spi_sel_n_i, power_off_pin_i}),
        .sync_o({s_sclk, s_mosi, s_sel_n, pwr_off})
    );

    step_timer u_tmr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .load_i(tmr_load),
        .value_i(tmr_val),
        .expire_o(tmr_exp)
    );

    // ==========================================================
    // Request decode
    wire tx_req = mode[`M_TX];
    wire rx_req = mode[`M_RX];
    wire any_req = tx_req | rx_req;
    wire pll_keep = mode[`M_PLL];
    // Tune also runs the crystal without its own bit
    wire xtal_keep = mode[`M_XT] | pll_keep; // RL14
    wire in_seq = (state != S_OFF) && (state != S_POR)
                  && (state != S_IDLE);
    wire idle = (state == S_IDLE);
    wire powered = (state != S_OFF) && (state != S_POR);

    // ==========================================================
    // Serial edge detection; the frame is refused in shutdown
    wire sel = ~s_sel_n && (state != S_OFF); // RL3
    wire rise = sel & s_sclk & ~sclk_d;
    wire fall = sel & ~s_sclk & sclk_d;
    wire byte_end = rise && (bit_cnt == `LAST_BIT);
    wire wr_fire = byte_end & hdr_done & is_write;
    wire [7:0] wr_data = {shin, s_mosi};
    wire rd_load = byte_end & ~(hdr_done ? is_write : shin[6]);
    wire rd_take = rd_load && ((rd_addr == `REG_INT_STAT2)
                   || (rd_addr == `REG_INT_STAT1));
    wire soft_rst = wr_fire && (addr == `REG_MODE)
                    && wr_data[`M_SWRES];

    // Address of the byte about to be shifted out
    always @*
    begin
        if (hdr_done)
            rd_addr = addr + 7'h01;
        else
            rd_addr = {shin[5:0], s_mosi};
    end

    // ==========================================================
    // Read multiplexer; unmapped offsets read zero
    always @*
    begin
        case (rd_addr)
            `REG_DEV_STATUS:
                rdata = {modem_flags_i,
                         state == S_PA || state == S_TX
                         || state == S_RXFE || state == S_ADC
                         || state == S_RX,
                         (state == S_PA || state == S_TX) ? `CPS_TX :
                         (state == S_RXFE || state == S_ADC
                          || state == S_RX) ? `CPS_RX :
                         `CPS_IDLE}; // RL20
            `REG_INT_STAT2: rdata = int_stat2;
            `REG_INT_EN2: rdata = int_en2;
            `REG_MODE: rdata = mode;
            `REG_CAL: rdata = cal;
            `REG_OSC: rdata = osc;
            default: rdata = `ZERO_BYTE;
        endcase
    end

    // ==========================================================
    // Serial slave: header then data bytes with address increment
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sclk_d <= 1'b0;
            bit_cnt <= 3'h0;
            hdr_done <= 1'b0;
            is_write <= 1'b0;
            addr <= 7'h00;
            shin <= 7'h00;
            shout <= `ZERO_BYTE;
            spi_miso_o <= 1'b1;
            spi_miso_oe_o <= 1'b0;
        end
        else if (ce_i)
        begin
            sclk_d <= s_sclk;
            if (!sel)
            begin
                bit_cnt <= 3'h0;
                hdr_done <= 1'b0;
                spi_miso_o <= 1'b1;
                spi_miso_oe_o <= 1'b0;
            end
            else
            begin
                spi_miso_oe_o <= 1'b1;
                if (rise)
                begin
                    shin <= {shin[5:0], s_mosi};
                    bit_cnt <= bit_cnt + 3'h1;
                end
                // Header: write flag then 7-bit address
                if (byte_end && !hdr_done)
                begin
                    hdr_done <= 1'b1; // RL23
                    is_write <= shin[6]; // RL23
                    addr <= {shin[5:0], s_mosi};
                end
                else if (byte_end)
                    addr <= addr + 7'h01; // RL23
                if (rd_load)
                    shout <= rdata;
                // Read data leaves on falling edges, MSB first
                if (fall && hdr_done && !is_write)
                begin
                    spi_miso_o <= shout[7];
                    shout <= {shout[6:0], 1'b0};
                end
            end
        end
    end

    // ==========================================================
    // Register file; contents lost in shutdown and power-on reset
    wire ev_por = (state == S_POR) & tmr_exp;
    wire ev_rdy = (state == S_XTAL) & tmr_exp;
    wire [7:0] set_bits = {6'h00, ev_rdy, ev_por};

    always @(posedge clk_i)
    begin
        if (rst_i || (ce_i && (pwr_off || state == S_POR || soft_rst)))
        begin
            mode <= `MODE_RST; // RL6
            cal <= `CAL_RST;
            osc <= `OSC_RST;
            int_en2 <= `INT_EN2_RST;
            int_stat2 <= set_bits;
            por_pending <= ev_por;
        end
        else if (ce_i)
        begin
            if (wr_fire && addr == `REG_MODE)
                mode <= wr_data & 8'h7F;
            if (wr_fire && addr == `REG_CAL)
                cal <= wr_data;
            if (wr_fire && addr == `REG_OSC)
                osc <= wr_data;
            if (wr_fire && addr == `REG_INT_EN2)
                int_en2 <= wr_data;
            // New events win over the read clear
            int_stat2 <= (int_stat2 & ~(int_en2 & {8{rd_take}}))
                         | set_bits; // RL24
            if (ev_por)
                por_pending <= 1'b1;
            else if (rd_take)
                por_pending <= 1'b0; // RL7
        end
    end

    // ==========================================================
    // Next state and step timer loads
    always @*
    begin
        next_state = state;
        tmr_load = 1'b0;
        tmr_val = {`TMR_W{1'b0}};
        case (state)
            S_OFF:
                // Falling power-off pin starts power-on reset
                if (!pwr_off)
                begin
                    next_state = S_POR; // RL5
                    tmr_load = 1'b1;
                    tmr_val = POR_CYCLES; // RL19
                end
            S_POR:
                if (tmr_exp)
                    next_state = S_IDLE; // RL6
            S_IDLE:
                // Skip steps the idle sub-mode already covers
                if (any_req && pll_keep)
                begin
                    next_state = S_SETTLE; // RL17
                    tmr_load = 1'b1;
                    tmr_val = `CYC_SETTLE;
                end
                else if (any_req && xtal_keep)
                    next_state = S_PLL_ON; // RL17
                else if (any_req)
                begin
                    next_state = S_XTAL; // RL15 RL16
                    tmr_load = 1'b1;
                    tmr_val = XTAL_CYCLES;
                end
            S_XTAL:
                if (tmr_exp)
                    next_state = S_PLL_ON;
            S_PLL_ON:
                if (cal[`CAL_SKIP_VCO])
                begin
                    next_state = S_SETTLE; // RL18
                    tmr_load = 1'b1;
                    tmr_val = `CYC_SETTLE;
                end
                else
                begin
                    next_state = S_VCO; // RL18
                    tmr_load = 1'b1;
                    tmr_val = `CYC_VCO;
                end
            S_VCO:
                if (tmr_exp)
                begin
                    next_state = S_SETTLE;
                    tmr_load = 1'b1;
                    tmr_val = `CYC_SETTLE;
                end
            S_SETTLE:
                if (tmr_exp && tx_req)
                begin
                    next_state = S_PA; // RL15
                    tmr_load = 1'b1;
                    tmr_val = `CYC_PA;
                end
                else if (tmr_exp)
                    next_state = S_RXFE; // RL16
            S_PA:
                if (tmr_exp)
                    next_state = S_TX;
            S_RXFE:
            begin
                next_state = S_ADC; // RL16
                tmr_load = 1'b1;
                tmr_val = `CYC_ADC;
            end
            S_ADC:
                if (tmr_exp)
                    next_state = S_RX;
            S_TX, S_RX:
                // Turnaround resettles the synthesizer
                if ((state == S_TX) ? (!tx_req && rx_req)
                                    : tx_req)
                begin
                    next_state = S_SETTLE; // RL19
                    tmr_load = 1'b1;
                    tmr_val = `CYC_SETTLE;
                end
            default:
                next_state = S_OFF;
        endcase
        // Dropped request falls back to the selected idle sub-mode
        if (in_seq && !any_req)
        begin
            next_state = S_IDLE; // RL25
            tmr_load = 1'b0;
        end
    end

    // ==========================================================
    // State register; pin high forces shutdown from anywhere
    always @(posedge clk_i)
    begin
        if (rst_i)
            state <= S_OFF;
        else if (ce_i)
        begin
            if (pwr_off)
                state <= S_OFF; // RL1 RL3
            else if (soft_rst)
                state <= S_IDLE; // RL6
            else
                state <= next_state; // RL1
        end
    end

    // ==========================================================
    // Block enables; low-power sub-modes wait for status read
    wire lp_ok = ~por_pending;
    // Standby and sleep: low-power regulator alone
    wire next_lpreg = idle & lp_ok & ~xtal_keep
                      & ~mode[`M_LBD] & ~mode[`M_TS]; // RL8 RL10 RL21
    wire next_main = powered & ~next_lpreg; // RL21
    // Crystal held in ready and tune, or until low power allowed
    wire next_xtal = (idle & (xtal_keep | ~lp_ok)) | in_seq; // RL12
    wire next_pll = (idle & pll_keep) | (in_seq && state != S_XTAL); // RL14
    wire next_buf_off = osc[`OSC_BUFOVR] & next_xtal;
    wire next_wt = powered & lp_ok & mode[`M_WT]; // RL10
    wire next_lbd = powered & mode[`M_LBD]; // RL11
    wire next_ts = powered & mode[`M_TS]; // RL11
    wire next_irq_n = ~|(int_stat2 & int_en2); // RL24

    // ==========================================================
    // Output registers
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            interrupt_out_n_o <= 1'b1;
            main_regulator_en_o <= 1'b0;
            low_power_regulator_en_o <= 1'b0;
            xtal_en_o <= 1'b0;
            xtal_buf_off_o <= 1'b0;
            pll_en_o <= 1'b0;
            vco_cal_o <= 1'b0;
            pa_en_o <= 1'b0;
            rx_front_end_en_o <= 1'b0;
            adc_cal_o <= 1'b0;
            modem_rx_en_o <= 1'b0;
            wake_timer_en_o <= 1'b0;
            lbd_en_o <= 1'b0;
            temp_sensor_en_o <= 1'b0;
        end
        else if (ce_i)
        begin
            interrupt_out_n_o <= next_irq_n | ~powered;
            main_regulator_en_o <= next_main; // RL15 RL16
            low_power_regulator_en_o <= next_lpreg;
            xtal_en_o <= next_xtal;
            xtal_buf_off_o <= next_buf_off;
            pll_en_o <= next_pll;
            vco_cal_o <= (state == S_VCO); // RL18
            pa_en_o <= (state == S_PA) || (state == S_TX); // RL15
            rx_front_end_en_o <= (state == S_RXFE)
                                 || (state == S_ADC)
                                 || (state == S_RX); // RL16
            adc_cal_o <= (state == S_ADC); // RL16
            modem_rx_en_o <= (state == S_RX); // RL16
            wake_timer_en_o <= next_wt; // RL2
            lbd_en_o <= next_lbd;
            temp_sensor_en_o <= next_ts;
        end
    end
endmodule // radio_mode_sequencer

/* File: src/radio_seq_consts.vh */
// Constants for the radio operating-mode sequencer
// Behaviour
// RL1 - Four primary states: shutdown, idle, transmit, receive.
// RL2 - Idle offers five sub-modes chosen by the mode control register.
// RL3 - Power-off pin high: shutdown, registers lost, serial access refused.
// RL4 - Host holds power-off pin low except when shutdown is intended.
// RL5 - Power-on reset starts after power-off pin falls.
// RL6 - After reset, soft reset or shutdown exit, settle in ready.
// RL7 - Low-power sub-modes need interrupt status read after power-on reset.
// RL8 - Mode register zero selects standby; registers stay accessible.
// RL9 - Host reads interrupt status in low-power sub-modes for minimum current.
// RL10 - Mode value 40h selects sleep with wake-up timer enabled.
// RL11 - Sensor sub-mode enables battery detector and temperature sensor per bits.
// RL12 - Crystal keep-on bit selects ready, crystal stays running.
// RL13 - Host writes 02h to oscillator control; clears bit 1 to leave.
// RL14 - Synthesizer keep-on bit selects tune; crystal enabled automatically.
// RL15 - Transmit entry: regulators, crystal, PLL, VCO cal, settle, ramp, transmit.
// RL16 - Receive entry: regulators, crystal, PLL, cal, settle, front end, ADC cal.
// RL17 - Steps already satisfied by current idle sub-mode are skipped.
// RL18 - VCO calibration runs at each PLL enable unless skip bit set. Here tune enables the PLL without calibration.
// RL19 - Response: 16.21 ms, 1.21 ms, 210 us, 200 us by start mode.
// RL20 - Status register 02 reports modem flags, lock and power state.
// RL21 - Low-power regulator alone only in standby and sleep.
// RL22 - Host avoids routing converter to a pin in standby or sleep.
// RL23 - Serial frame: write flag, 7-bit address, 8 data bits.
// RL24 - Reading interrupt status clears enabled bits, releases interrupt output.
// RL25 - Clearing transmit or receive request returns to selected idle sub-mode.
`ifndef RADIO_SEQ_CONSTS_VH
`define RADIO_SEQ_CONSTS_VH
// ==========================================================
// Register offsets
`define REG_DEV_STATUS 7'h02
`define REG_INT_STAT1 7'h03
`define REG_INT_STAT2 7'h04
`define REG_INT_EN2 7'h06
`define REG_MODE 7'h07
`define REG_CAL 7'h55
`define REG_OSC 7'h62
// ==========================================================
// Reset values
`define INT_EN2_RST 8'h01
`define MODE_RST 8'h01
`define CAL_RST 8'h04
`define OSC_RST 8'h00
`define ZERO_BYTE 8'h00
// ==========================================================
// Field positions
`define M_SWRES 7
`define M_WT 6
`define M_LBD 5
`define M_TS 4
`define M_RX 3
`define M_TX 2
`define M_PLL 1
`define M_XT 0
`define CAL_SKIP_VCO 0
`define OSC_BUFOVR 1
`define I_POR 0
`define I_CHIPRDY 1
`define LAST_BIT 3'h7
// ==========================================================
// Power state codes
`define CPS_IDLE 2'h0
`define CPS_RX 2'h1
`define CPS_TX 2'h2
// ==========================================================
// Timing, in microseconds, and cycle counts
// Sized to the timer width so each product lands in the step counter
`define CLK_MHZ 19'h14
`define T_POR_US 19'h3A98
`define T_XTAL_US 19'h3E8
`define T_VCO_US 19'hA
`define T_SETTLE_US 19'hB4
`define T_PA_US 19'h14
`define T_ADC_US 19'h14
`define TMR_W 19
`define CYC_POR (`T_POR_US * `CLK_MHZ)
`define CYC_XTAL (`T_XTAL_US * `CLK_MHZ)
`define CYC_VCO (`T_VCO_US * `CLK_MHZ)
`define CYC_SETTLE (`T_SETTLE_US * `CLK_MHZ)
`define CYC_PA (`T_PA_US * `CLK_MHZ)
`define CYC_ADC (`T_ADC_US * `CLK_MHZ)
`endif

/* File: src/pin_sync.v */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module pin_sync #(parameter W = 1)
(
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire [W-1:0] init_i,
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] stage1;
    reg [W-1:0] stage2;

    // ==========================================================
    // Synchroniser chain, one generate branch per bit
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    stage1[i] <= init_i[i];
                    stage2[i] <= init_i[i];
                end
                else if (ce_i)
                begin
                    stage1[i] <= async_i[i];
                    stage2[i] <= stage1[i];
                end
            end
        end
    endgenerate

    // Both stages start at the idle level, so no false edge follows reset
    assign sync_o = stage2;
endmodule // pin_sync

/* File: src/step_timer.v */
// Down-counter timing one sequencer step
`timescale 1ns/100ps
`include "radio_seq_consts.vh"
module step_timer
(
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire load_i,
    input wire [`TMR_W-1:0] value_i,
    output reg expire_o
);
    reg [`TMR_W-1:0] cnt;

    // ==========================================================
    // Count; one-cycle pulse after the last count
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt <= {`TMR_W{1'b0}};
            expire_o <= 1'b0;
        end
        else if (ce_i)
        begin
            expire_o <= (cnt == {{(`TMR_W-1){1'b0}}, 1'b1}) & ~load_i;
            if (load_i)
                cnt <= value_i;
            else if (cnt != {`TMR_W{1'b0}})
                cnt <= cnt - {{(`TMR_W-1){1'b0}}, 1'b1};
        end
    end
endmodule // step_timer

/* File: testbench/radio_host_model.sv */
// Host controller model driving the serial register port
`timescale 1ns/100ps
module radio_host_model
(
    input wire miso_i,
    input wire miso_oe_i,
    output reg sclk_o,
    output reg mosi_o,
    output reg sel_n_o
);
    // =====
    // Pull-up on the data-out line when the device lets go
    wire line = miso_oe_i ? miso_i : 1'b1;
    initial
    begin
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        sel_n_o = 1'b1;
    end
    // One 16-bit frame, MSB first, 400 ns bit period
    task xfer(input [15:0] w, output [7:0] r);
        integer i;
    begin
        #407 sel_n_o = 1'b0;
        for (i = 15; i >= 0; i = i - 1)
        begin
            mosi_o = w[i];
            #200 sclk_o = 1'b1;
            #200 r = {r[6:0], line};
            sclk_o = 1'b0;
        end
        #200 sel_n_o = 1'b1;
        // No stale bit left on a released line
        mosi_o = ~w[0];
    end
    endtask
endmodule // radio_host_model

/* File: testbench/radio_mode_sequencer_properties.sv */
// Assertion checker for the radio operating-mode sequencer
`timescale 1ns/100ps
module radio_seq_checker
(
    input wire clk_i,
    input wire rst_i,
    input wire power_off_pin_i,
    input wire spi_sel_n_i,
    input wire spi_miso_o,
    input wire spi_miso_oe_o,
    input wire main_regulator_en_o,
    input wire low_power_regulator_en_o,
    input wire xtal_en_o,
    input wire pll_en_o,
    input wire vco_cal_o,
    input wire pa_en_o,
    input wire rx_front_end_en_o,
    input wire adc_cal_o,
    input wire modem_rx_en_o
);
    // =====
    // One domain, so clock and reset are given once
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Calibration keeps the loop on for its first 8 cycles
    sequence s_cal_run;
        (pll_en_o && vco_cal_o)[*8];
    endsequence
    a_shut_off: assert property (
        power_off_pin_i[*6] |-> !main_regulator_en_o
        && !low_power_regulator_en_o && !xtal_en_o) else $error("on in off");
    a_lp_alone: assert property (
        low_power_regulator_en_o |-> !main_regulator_en_o && !xtal_en_o)
        else $error("both regulators");
    a_pa_locked: assert property (
        pa_en_o |-> pll_en_o && xtal_en_o && !rx_front_end_en_o)
        else $error("amp without loop");
    a_rx_locked: assert property (
        modem_rx_en_o |-> pll_en_o && rx_front_end_en_o && !pa_en_o)
        else $error("rx without loop");
    a_cal_run: assert property (
        $rose(vco_cal_o) |-> s_cal_run) else $error("short calibration");
    a_pa_settled: assert property (
        $rose(pa_en_o) |-> $past(pll_en_o, 8) && !vco_cal_o)
        else $error("amp too early");
    a_adc_then_rx: assert property (
        $rose(modem_rx_en_o) |-> $past(adc_cal_o) || $past(adc_cal_o, 2)
        || $past(adc_cal_o, 3)) else $error("rx before adc cal");
    a_miso_idle: assert property (
        spi_sel_n_i[*5] |-> spi_miso_o && !spi_miso_oe_o)
        else $error("data out driven");
endmodule // radio_seq_checker
bind radio_mode_sequencer radio_seq_checker chk (.clk_i(clk_i),
    .rst_i(rst_i), .power_off_pin_i(power_off_pin_i),
    .spi_sel_n_i(spi_sel_n_i), .spi_miso_o(spi_miso_o),
    .spi_miso_oe_o(spi_miso_oe_o), .main_regulator_en_o(main_regulator_en_o),
    .low_power_regulator_en_o(low_power_regulator_en_o),
    .xtal_en_o(xtal_en_o), .pll_en_o(pll_en_o), .vco_cal_o(vco_cal_o),
    .pa_en_o(pa_en_o), .rx_front_end_en_o(rx_front_end_en_o),
    .adc_cal_o(adc_cal_o), .modem_rx_en_o(modem_rx_en_o));

/* File: testbench/radio_mode_sequencer_tb.sv */
// Testbench for the radio operating-mode sequencer
`timescale 1ns/100ps
module radio_mode_sequencer_tb;
    // =====
    // Short counts keep the run brief
    localparam integer POR = 50;
    localparam integer XT = 40;
    localparam [31:0] MODES = 32'h00403002;
    localparam [51:0] ENS = {13'h0800, 13'h0804, 13'h1003, 13'h1500};
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg off = 1'b0;
    reg cal_seen = 1'b0;
    reg [7:0] rd;
    wire sclk, mosi, sel_n, miso, miso_oe, irq_n;
    wire [12:0] en;
    integer errors = 0;
    integer n_tests = 0;
    integer t;
    radio_mode_sequencer #(.POR_CYCLES(POR), .XTAL_CYCLES(XT)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .power_off_pin_i(off),
        .spi_sclk_i(sclk), .spi_mosi_i(mosi), .spi_sel_n_i(sel_n),
        .modem_flags_i(5'h15), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
        .interrupt_out_n_o(irq_n), .main_regulator_en_o(en[12]),
        .low_power_regulator_en_o(en[11]), .xtal_en_o(en[10]),
        .xtal_buf_off_o(en[9]), .pll_en_o(en[8]), .vco_cal_o(en[7]),
        .pa_en_o(en[6]), .rx_front_end_en_o(en[5]), .adc_cal_o(en[4]),
        .modem_rx_en_o(en[3]), .wake_timer_en_o(en[2]), .lbd_en_o(en[1]),
        .temp_sensor_en_o(en[0]));
    radio_host_model host (.miso_i(miso), .miso_oe_i(miso_oe),
        .sclk_o(sclk), .mosi_o(mosi), .sel_n_o(sel_n));
    // Clock and calibration watch
    always #25 clk_i = ~clk_i;
    always @(posedge en[7]) cal_seen = 1'b1;
    // =====
    // Shared tasks
    task check(input string nm, input [12:0] seen, input [12:0] exp);
    begin
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task end_sim;
    begin
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    task cyc(input integer n);
    begin
        repeat (n) @(posedge clk_i);
        #2;
    end
    endtask
    task wr(input [6:0] a, input [7:0] d);
        host.xfer({1'b1, a, d}, rd);
    endtask
    task rdr(input [6:0] a);
        host.xfer({1'b0, a, 8'h00}, rd);
    endtask
    // Bounded count of cycles until an enable rises
    task timed(input integer b, input integer exp);
    begin
        t = 0;
        while (en[b] !== 1'b1 && t < 6000)
        begin
            cyc(1);
            t = t + 1;
        end
        check("latency", t >= exp - 10 && t <= exp + 15, 1);
    end
    endtask
    // =====
    // Scenarios
    task t_por;
    begin
        timed(10, POR + 3);
        cyc(2);
        check("ready", en, 13'h1400);
        check("irq", irq_n, 0);
        rdr(7'h04);
        cyc(3);
        check("irq", irq_n, 1);
        rdr(7'h02);
        check("status", rd, 8'hA8);
    end
    endtask
    task t_idle;
        integer k;
    begin
        for (k = 0; k < 4; k = k + 1)
        begin
            wr(7'h07, MODES[31-8*k -: 8]);
            rdr(7'h04);
            cyc(300);
            check("irq", irq_n, 1);
            check("idle", en, ENS[51-13*k -: 13]);
            rdr(7'h07);
            check("mode", rd, MODES[31-8*k -: 8]);
        end
    end
    endtask
    task t_tx;
    begin
        wr(7'h07, 8'h00);
        cyc(5);
        cal_seen = 1'b0;
        wr(7'h07, 8'h04);
        timed(6, XT + 3801);
        check("cal", cal_seen, 1);
        cyc(410);
        rdr(7'h02);
        check("status", rd, 8'hAE);
        wr(7'h07, 8'h08);
        timed(3, 4001);
        rdr(7'h02);
        check("status", rd, 8'hAD);
        wr(7'h07, 8'h01);
        cyc(5);
        check("back", en, 13'h1400);
        wr(7'h62, 8'h02);
        cyc(5);
        check("buffer", en, 13'h1600);
        wr(7'h62, 8'h00);
    end
    endtask
    task t_skip;
    begin
        wr(7'h55, 8'h05);
        cyc(5);
        cal_seen = 1'b0;
        wr(7'h07, 8'h05);
        timed(6, 3601);
        check("cal", cal_seen, 0);
    end
    endtask
    task t_off;
    begin
        @(posedge clk_i);
        #2 off = 1'b1;
        cyc(8);
        check("off", en, 0);
        rdr(7'h02);
        check("refused", rd, 8'hFF);
        @(posedge clk_i);
        #2 off = 1'b0;
        timed(10, POR + 3);
        cyc(2);
        check("ready", en, 13'h1400);
        rdr(7'h55);
        check("lost", rd, 8'h04);
        wr(7'h07, 8'h02);
        cyc(5);
        wr(7'h07, 8'h80);
        cyc(5);
        rdr(7'h07);
        check("soft", rd, 8'h01);
    end
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk_i);
        #2 rst_i = 1'b0;
        t_por;
        t_idle;
        t_tx;
        t_skip;
        t_off;
        end_sim;
    end
    // Watchdog at about twice the expected run
    initial
    begin
        #2000000;
        errors = errors + 1;
        end_sim;
    end
endmodule // radio_mode_sequencer_tb
